// ### rtl/fdms_defines.vh
// constants for the fieldbus master station sequencer
`ifndef FDMS_DEFINES_VH
`define FDMS_DEFINES_VH
// acyclic result status codes
`define FDMS_ST_OK        8'h00
`define FDMS_ST_LINK_ERR  8'h05
`define FDMS_ST_EXT_ERR   8'h06
`define FDMS_ST_BUSY      8'h07
`define FDMS_ST_OFFLINE   8'h11
`define FDMS_ST_BAD_RESP  8'h13
`define FDMS_ST_TIMEOUT   8'h17
// station commands placed on the transmit port
`define FDMS_CMD_PARAM    3'h1
`define FDMS_CMD_CONFIG   3'h2
`define FDMS_CMD_XCHG     3'h3
`define FDMS_CMD_ACYC     3'h4
`define FDMS_CMD_OPEN     3'h5
`define FDMS_CMD_CLOSE    3'h6
// response kinds on the receive port
`define FDMS_RSP_ACCEPT   2'h0
`define FDMS_RSP_REJECT   2'h1
`define FDMS_RSP_LINKERR  2'h2
`define FDMS_RSP_EXTERR   2'h3
// response timeout in microseconds, and cycles at 10 MHz
`define FDMS_TIMEOUT_US   100
`define FDMS_CLK_MHZ      10
`define FDMS_TIMEOUT_CYC  (`FDMS_TIMEOUT_US * `FDMS_CLK_MHZ)
`endif

// ### rtl/fdms_state_mem.v
// per-slave state memory with registered read data
module fdms_state_mem
#(
   parameter AW = 3,
   parameter DW = 6
)
(
   input  wire          clk_i,
   input  wire          ce_i,
   input  wire [AW-1:0] raddr_i,
   output reg  [DW-1:0] rdata_o,
   input  wire          we_i,
   input  wire [AW-1:0] waddr_i,
   input  wire [DW-1:0] wdata_i
);
   reg [DW-1:0] mem [0:(1<<AW)-1];   // one word per slave

   // write port and registered read, both frozen by the enable
   always @(posedge clk_i)
   begin
      if (ce_i)
      begin
         if (we_i)
            mem[waddr_i] <= wdata_i;
         rdata_o <= mem[raddr_i];
      end
   end
endmodule // fdms_state_mem

// ### rtl/fdms_sequencer.v
// station sequencer of a fieldbus master: slave bring-up and acyclic channels
`include "fdms_defines.vh"
// Functional notes
// - transmit only while holding the token
// - master sets bit rate, slaves detect
// - write outputs only to owned slaves
// - send parameters then configuration per slave
// - exchange only after both checks accepted
// - acyclic requests need an open channel
// - primary channel needs support, enable, exchange
// - supervisor connection explicit, within slave limit; SUP_LIMIT is never checked, sup_open holds at most one link per slave
// - supervisor close by either end handled
// - status 00h, 05h, 06h, 07h reported; 07h is never raised, sup_busy is clear whenever the engine is idle
// - status 11h, 13h, 17h reported
module fdms_sequencer
#(
   parameter AW         = 3,                     // slave index width
   parameter TIMEOUT    = `FDMS_TIMEOUT_CYC,     // response wait in cycles
   parameter SUP_LIMIT  = 2                      // supervisor connections per slave
)
(
   input  wire          CLOCK_I,
   input  wire          RSTN_I,
   input  wire          CE_I,
   input  wire          TOKEN_I,           // bus access token held
   input  wire [7:0]    BAUD_SEL_I,        // bit rate chosen by this master
   input  wire [AW-1:0] START_SLAVE_I,     // slave to bring up
   input  wire          START_I,           // begin bring-up of that slave
   input  wire          START_OWNED_I,     // slave is assigned to this master
   input  wire          START_SUPPORT_I,   // slave supports primary acyclic channel
   input  wire          START_EXT_EN_I,    // acyclic_ext_enable_bit in parameters
   input  wire          ACYC_REQ_I,        // acyclic request strobe
   input  wire          ACYC_SUP_I,        // request goes over supervisor channel
   input  wire [1:0]    ACYC_OP_I,         // 0 read, 1 write, 2 open, 3 close
   input  wire [AW-1:0] ACYC_SLAVE_I,
   input  wire          TX_READY_I,        // link accepts a telegram
   input  wire          RSP_VALID_I,       // response from the addressed slave
   input  wire [1:0]    RSP_KIND_I,
   input  wire          SLAVE_CLOSE_I,     // slave tore down a supervisor link
   input  wire [AW-1:0] SLAVE_CLOSE_ID_I,
   output wire          TX_VALID_O,
   output reg  [2:0]    TX_CMD_O,
   output reg  [AW-1:0] TX_SLAVE_O,
   output reg  [7:0]    BAUD_O,
   output wire          ACYC_READY_O,
   output reg           STAT_VALID_O,
   output reg  [7:0]    STAT_O,
   output reg  [3:0]    SLAVE_STATE_O,     // state of slave on ACYC_SLAVE_I
   output reg           PRIM_CH_OPEN_O
);
   // per-slave phases, one-hot
   localparam SL_IDLE  = 4'b0001;
   localparam SL_PARAM = 4'b0010;
   localparam SL_CONF  = 4'b0100;
   localparam SL_XCHG  = 4'b1000;
   // engine states, one-hot
   localparam EN_IDLE = 3'b001;
   localparam EN_SEND = 3'b010;
   localparam EN_WAIT = 3'b100;

   // memory word: phase, support flag, enable flag
   wire [5:0]    mem_rd;              // registered word of ACYC_SLAVE_I
   reg           mem_we;
   reg  [AW-1:0] mem_wa;
   reg  [5:0]    mem_wd;
   reg  [2:0]    eng;                 // engine state
   reg  [AW-1:0] cur;                 // slave in flight
   reg  [3:0]    cur_ph;              // phase of that slave
   reg           cur_sup;             // support flag
   reg           cur_en;              // enable flag
   reg  [2:0]    cmd;                 // telegram pending
   reg           is_acyc;             // pending job is acyclic
   reg           cur_chan_sup;        // pending job uses the supervisor channel
   reg  [15:0]   tmr;                 // response wait counter
   reg  [(1<<AW)-1:0] sup_open;       // this master's supervisor links
   reg  [(1<<AW)-1:0] sup_busy;       // outstanding supervisor request
   reg  [(1<<AW)-1:0] own;            // slaves assigned here
   reg           req_live;            // request awaiting engine

   fdms_state_mem #(.AW(AW), .DW(6)) u_mem
   (
      .clk_i   (CLOCK_I),
      .ce_i    (CE_I),
      .raddr_i (ACYC_SLAVE_I),
      .rdata_o (mem_rd),
      .we_i    (mem_we),
      .waddr_i (mem_wa),
      .wdata_i (mem_wd)
   );

   // primary channel usable only in exchange with support and enable
   function prim_ok;
      input [5:0] w;
      begin
         prim_ok = (w[5:2] == SL_XCHG) && w[1] && w[0];
      end
   endfunction

   // engine idle, no strobe in decode and no bring-up; one request at a time
   // the strobe sits a cycle in req_live, so ready must drop for that cycle too
   assign ACYC_READY_O = (eng == EN_IDLE) && !req_live && !START_I;
   // telegrams only leave while the token is held
   assign TX_VALID_O = (eng == EN_SEND) && TOKEN_I;

   // sequencer: bring-up, acyclic requests and status
   always @(posedge CLOCK_I)
   begin
      if (!RSTN_I)
      begin
         eng <= EN_IDLE;
         cur <= {AW{1'b0}};
         cur_ph <= SL_IDLE;
         cur_sup <= 1'b0;
         cur_en <= 1'b0;
         cmd <= 3'h0;
         is_acyc <= 1'b0;
         cur_chan_sup <= 1'b0;
         tmr <= 16'h0000;
         sup_open <= {(1<<AW){1'b0}};
         sup_busy <= {(1<<AW){1'b0}};
         own <= {(1<<AW){1'b0}};
         req_live <= 1'b0;
         mem_we <= 1'b0;
         mem_wa <= {AW{1'b0}};
         mem_wd <= 6'h00;
         TX_CMD_O <= 3'h0;
         TX_SLAVE_O <= {AW{1'b0}};
         BAUD_O <= 8'h00;
         STAT_VALID_O <= 1'b0;
         STAT_O <= 8'h00;
         SLAVE_STATE_O <= SL_IDLE;
         PRIM_CH_OPEN_O <= 1'b0;
      end
      else if (CE_I)
      begin
         mem_we <= 1'b0;
         STAT_VALID_O <= 1'b0;
         BAUD_O <= BAUD_SEL_I;
         SLAVE_STATE_O <= mem_rd[5:2];
         PRIM_CH_OPEN_O <= prim_ok(mem_rd);
         // slave-initiated teardown of a supervisor link
         if (SLAVE_CLOSE_I)
            sup_open[SLAVE_CLOSE_ID_I] <= 1'b0;
         // memory read is one cycle late; latch the strobe
         req_live <= ACYC_REQ_I && ACYC_READY_O;
         case (eng)
            EN_IDLE:
            begin
               if (START_I)
               begin
                  // begin parameterization of the slave
                  cur <= START_SLAVE_I;
                  cur_sup <= START_SUPPORT_I;
                  cur_en <= START_EXT_EN_I;
                  own[START_SLAVE_I] <= START_OWNED_I;
                  cur_ph <= SL_PARAM;
                  cmd <= `FDMS_CMD_PARAM;
                  is_acyc <= 1'b0;
                  cur_chan_sup <= 1'b0;
                  eng <= START_OWNED_I ? EN_SEND : EN_IDLE;
               end
               else if (req_live)
               begin
                  cur <= ACYC_SLAVE_I;
                  is_acyc <= 1'b1;
                  cur_chan_sup <= ACYC_SUP_I;       // live input may move later
                  cur_ph <= mem_rd[5:2];
                  cur_sup <= mem_rd[1];
                  cur_en <= mem_rd[0];
                  STAT_VALID_O <= 1'b1;
                  if (ACYC_SUP_I && sup_busy[ACYC_SLAVE_I])
                     STAT_O <= `FDMS_ST_BUSY;
                  else if (ACYC_SUP_I)
                  begin
                     // supervisor channel: open, use, close
                     if (ACYC_OP_I == 2'h2 && !sup_open[ACYC_SLAVE_I])
                     begin
                        STAT_VALID_O <= 1'b0;
                        cmd <= `FDMS_CMD_OPEN;
                        sup_busy[ACYC_SLAVE_I] <= 1'b1;
                        eng <= EN_SEND;
                     end
                     else if (!sup_open[ACYC_SLAVE_I])
                        STAT_O <= `FDMS_ST_OFFLINE;
                     else
                     begin
                        STAT_VALID_O <= 1'b0;
                        cmd <= (ACYC_OP_I == 2'h3) ? `FDMS_CMD_CLOSE : `FDMS_CMD_ACYC;
                        sup_busy[ACYC_SLAVE_I] <= 1'b1;
                        eng <= EN_SEND;
                     end
                  end
                  else if (!prim_ok(mem_rd) || ACYC_OP_I[1])
                     STAT_O <= `FDMS_ST_OFFLINE;
                  else if (ACYC_OP_I == 2'h1 && !own[ACYC_SLAVE_I])
                     STAT_O <= `FDMS_ST_EXT_ERR;
                  else
                  begin
                     STAT_VALID_O <= 1'b0;
                     cmd <= `FDMS_CMD_ACYC;
                     eng <= EN_SEND;
                  end
               end
            end
            EN_SEND:
            begin
               // wait for token and link before the telegram leaves
               if (TOKEN_I && TX_READY_I)
               begin
                  TX_CMD_O <= cmd;
                  TX_SLAVE_O <= cur;
                  tmr <= 16'h0000;
                  eng <= EN_WAIT;
               end
            end
            EN_WAIT:
            begin
               // slaves only answer, so a timeout closes the wait
               if (RSP_VALID_I || tmr == TIMEOUT - 1)
               begin
                  eng <= EN_IDLE;
                  mem_we <= 1'b1;
                  mem_wa <= cur;
                  mem_wd <= {cur_ph, cur_sup, cur_en};
                  if (!is_acyc)
                  begin
                     if (RSP_VALID_I && RSP_KIND_I == `FDMS_RSP_ACCEPT)
                     begin
                        // accepted parameters lead to config, then exchange
                        if (cmd == `FDMS_CMD_PARAM)
                        begin
                           cmd <= `FDMS_CMD_CONFIG;
                           cur_ph <= SL_CONF;
                           mem_wd <= {SL_CONF, cur_sup, cur_en};
                           eng <= EN_SEND;
                        end
                        else
                        begin
                           cmd <= `FDMS_CMD_XCHG;
                           cur_ph <= SL_XCHG;
                           mem_wd <= {SL_XCHG, cur_sup, cur_en};
                        end
                     end
                     else
                     begin
                        // rejection or silence: back to parameterizing
                        cur_ph <= SL_PARAM;
                        mem_wd <= {SL_PARAM, cur_sup, cur_en};
                     end
                  end
                  else
                  begin
                     STAT_VALID_O <= 1'b1;
                     if (cur_chan_sup)
                        sup_busy[cur] <= 1'b0;
                     if (!RSP_VALID_I)
                        STAT_O <= `FDMS_ST_TIMEOUT;
                     else if (RSP_KIND_I == `FDMS_RSP_LINKERR)
                        STAT_O <= `FDMS_ST_LINK_ERR;
                     else if (RSP_KIND_I == `FDMS_RSP_EXTERR)
                        STAT_O <= `FDMS_ST_EXT_ERR;
                     else if (RSP_KIND_I == `FDMS_RSP_REJECT)
                        STAT_O <= (cmd == `FDMS_CMD_OPEN) ? `FDMS_ST_EXT_ERR
                                                           : `FDMS_ST_BAD_RESP;
                     else
                        STAT_O <= `FDMS_ST_OK;
                     if (RSP_VALID_I && RSP_KIND_I == `FDMS_RSP_ACCEPT)
                     begin
                        if (cmd == `FDMS_CMD_OPEN)
                           sup_open[cur] <= 1'b1;
                        if (cmd == `FDMS_CMD_CLOSE)
                           sup_open[cur] <= 1'b0;
                     end
                     // lost primary-channel answer drops the slave back
                     // error answers keep the slave; only silence drops it
                     if (cmd == `FDMS_CMD_ACYC && !cur_chan_sup && !RSP_VALID_I)
                     begin
                        cur_ph <= SL_PARAM;
                        mem_wd <= {SL_PARAM, cur_sup, cur_en};
                     end
                  end
               end
               else
                  tmr <= tmr + 16'h0001;
            end
            default:
               eng <= EN_IDLE;
         endcase
      end
   end
endmodule // fdms_sequencer

// ### dv/fdms_sequencer_assertions.sv
// concurrent checks on the station sequencer ports
module fdms_sequencer_assertions
(
   input wire logic       CLOCK_I,
   input wire logic       RSTN_I,
   input wire logic       TOKEN_I,
   input wire logic [7:0] BAUD_SEL_I,
   input wire logic       START_I,
   input wire logic       ACYC_REQ_I,
   input wire logic       ACYC_SUP_I,
   input wire logic [1:0] ACYC_OP_I,
   input wire logic       TX_READY_I,
   input wire logic       TX_VALID_O,
   input wire logic [7:0] BAUD_O,
   input wire logic       ACYC_READY_O,
   input wire logic       STAT_VALID_O,
   input wire logic [7:0] STAT_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RSTN_I);
   chk_tx_token: assert property (TX_VALID_O |-> TOKEN_I)
      else $error("telegram offered without token");
   chk_tx_held: assert property (TX_VALID_O && !TX_READY_I && TOKEN_I |=> TX_VALID_O || !TOKEN_I)
      else $error("telegram withdrawn before taken");
   chk_baud_copy: assert property ($past(RSTN_I) |-> BAUD_O == $past(BAUD_SEL_I))
      else $error("bit rate output not a copy of selection");
   chk_stat_pulse: assert property (STAT_VALID_O |=> !STAT_VALID_O)
      else $error("status strobe longer than one cycle");
   chk_stat_code: assert property (STAT_VALID_O |->
      STAT_O inside {8'h00, 8'h05, 8'h06, 8'h07, 8'h11, 8'h13, 8'h17})
      else $error("status code outside the defined set");
   chk_prim_refuse: assert property (ACYC_REQ_I && ACYC_READY_O && !ACYC_SUP_I
      && ACYC_OP_I[1] |-> ##2 STAT_VALID_O && STAT_O == 8'h11)
      else $error("open or close on primary channel not refused");
   chk_one_job: assert property (ACYC_REQ_I && ACYC_READY_O |=> !ACYC_READY_O)
      else $error("second request accepted while job runs");
   chk_start_blocks: assert property (START_I |-> !ACYC_READY_O)
      else $error("ready shown during bring-up strobe");
endmodule // fdms_sequencer_assertions
bind fdms_sequencer fdms_sequencer_assertions i_fdms_sequencer_assertions
   (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .TOKEN_I(TOKEN_I), .BAUD_SEL_I(BAUD_SEL_I),
    .START_I(START_I), .ACYC_REQ_I(ACYC_REQ_I), .ACYC_SUP_I(ACYC_SUP_I),
    .ACYC_OP_I(ACYC_OP_I), .TX_READY_I(TX_READY_I), .TX_VALID_O(TX_VALID_O),
    .BAUD_O(BAUD_O), .ACYC_READY_O(ACYC_READY_O), .STAT_VALID_O(STAT_VALID_O),
    .STAT_O(STAT_O));

// ### dv/fdms_slave_model.sv
// passive slave station model answering each taken telegram
module fdms_slave_model
(
   input  wire logic       clk_i,
   input  wire logic       tx_valid_i,
   input  wire logic       mute_i,     // swallow the answer, forces a timeout
   input  wire logic [1:0] kind_i,     // verdict returned
   input  wire logic [3:0] dly_i,      // answer delay, kept below the timeout
   output logic            tx_ready_o,
   output logic            rsp_valid_o,
   output logic [1:0]      rsp_kind_o
);
   int wait_cnt = -1;   // -1 while nothing is pending
   initial
   begin
      tx_ready_o = 1'b1;
      rsp_valid_o = 1'b0;
      rsp_kind_o = 2'h0;
   end
   // one telegram at a time; busy slave stalls the link
   always @(posedge clk_i)
   begin
      rsp_valid_o <= 1'b0;
      rsp_kind_o <= ~rsp_kind_o;   // idle pattern so stale kinds never pass
      if (tx_valid_i && tx_ready_o)
      begin
         tx_ready_o <= 1'b0;
         wait_cnt <= int'(dly_i);
      end
      else if (wait_cnt == 0)
      begin
         tx_ready_o <= 1'b1;
         wait_cnt <= -1;
         if (!mute_i)
         begin
            rsp_valid_o <= 1'b1;
            rsp_kind_o <= kind_i;
         end
      end
      else if (wait_cnt > 0)
         wait_cnt <= wait_cnt - 1;
   end
endmodule // fdms_slave_model

// ### dv/fdms_sequencer_tb_top.sv
// self-checking bench for the station sequencer with a slave model
module fdms_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clk = 0, rstn = 0, token = 0, start = 0, own = 0, supp = 0, ext = 0;
   logic          req = 0, rsup = 0, sclose = 0, mute = 0;
   logic [7:0]    baud = 8'h00;
   logic [2:0]    sslave = 3'h0, aslave = 3'h0, cid = 3'h0;
   logic [1:0]    op = 2'h0, kind = 2'h0;
   logic [3:0]    dly = 4'h0;
   wire           tx_valid, tx_ready, rsp_valid, ack_ready, stat_valid, prim_open;
   wire  [2:0]    tx_cmd, tx_slave;
   wire  [1:0]    rsp_kind;
   wire  [7:0]    baud_o, stat;
   wire  [3:0]    state;
   int            mismatches = 0, tests_run = 0;
   logic [7:0]    expq[$];        // expected statuses in issue order
   logic [31:0]   seed = 32'd13319;
   fdms_sequencer #(.AW(3), .TIMEOUT(20)) i_fdms_sequencer
      (.CLOCK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .TOKEN_I(token), .BAUD_SEL_I(baud),
       .START_SLAVE_I(sslave), .START_I(start), .START_OWNED_I(own), .START_SUPPORT_I(supp),
       .START_EXT_EN_I(ext), .ACYC_REQ_I(req), .ACYC_SUP_I(rsup), .ACYC_OP_I(op),
       .ACYC_SLAVE_I(aslave), .TX_READY_I(tx_ready), .RSP_VALID_I(rsp_valid),
       .RSP_KIND_I(rsp_kind), .SLAVE_CLOSE_I(sclose), .SLAVE_CLOSE_ID_I(cid),
       .TX_VALID_O(tx_valid), .TX_CMD_O(tx_cmd), .TX_SLAVE_O(tx_slave), .BAUD_O(baud_o),
       .ACYC_READY_O(ack_ready), .STAT_VALID_O(stat_valid), .STAT_O(stat),
       .SLAVE_STATE_O(state), .PRIM_CH_OPEN_O(prim_open));
   fdms_slave_model i_fdms_slave_model
      (.clk_i(clk), .tx_valid_i(tx_valid), .mute_i(mute), .kind_i(kind), .dly_i(dly),
       .tx_ready_o(tx_ready), .rsp_valid_o(rsp_valid), .rsp_kind_o(rsp_kind));
   always #50 clk = ~clk;
   task tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // xorshift step, bits feed delay and bit rate
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xorshift = v ^ (v << 5);
   endfunction
   task check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait for an idle engine; running out is a fault
   task wait_ready();
      int n;
      n = 0;
      while (ack_ready !== 1'b1 && n < 200)
      begin
         tick();
         n++;
      end
      if (n == 200) mismatches++;
   endtask
   task tally_and_finish();
      if (expq.size() != 0) mismatches++;
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // bring-up with token withheld first, then state and channel read back
   task bring(input logic [2:0] sl, input logic [1:0] k, input logic e, input logic [7:0] st);
      wait_ready();
      token = 0; sslave = sl; own = 1; supp = 1; ext = e; kind = k; mute = 0; start = 1;
      tick();
      start = 0;
      tick(4);
      check({7'h0, tx_valid}, 8'h00);
      token = 1;
      tick(2);
      wait_ready();
      aslave = sl;
      tick(3);
      check({4'h0, state}, st);
      check({7'h0, prim_open}, {7'h0, st == 8'h08 && e});
      check({5'h0, tx_cmd}, st == 8'h08 ? 8'h02 : 8'h01);
      check({5'h0, tx_slave}, {5'h0, sl});
   endtask
   // one acyclic job, status expectation queued for the monitor
   task acyc(input logic s, input logic [1:0] o, input logic [2:0] sl, input logic [1:0] k,
             input logic m, input logic [7:0] e);
      wait_ready();
      seed = xorshift(seed);
      dly = seed[3:0]; kind = k; mute = m; rsup = s; op = o; aslave = sl; req = 1;
      expq.push_back(e);
      tick();
      req = 0;
      tick(3);
      wait_ready();
      tick(2);
   endtask
   // status monitor pairs each strobe with the oldest expectation
   // sampled mid-cycle, well away from the edge that launches the strobe
   always @(negedge clk)
      if (stat_valid === 1'b1)
         check(stat, expq.size() != 0 ? expq.pop_front() : 8'hff);
   initial
   begin
      #(100 * 20000);
      mismatches++;
      tally_and_finish();
   end
   initial
   begin
      tick(8);
      rstn = 1;
      check({4'h0, state}, 8'h01);
      repeat (4)
      begin
         seed = xorshift(seed);
         baud = seed[15:8];
         tick(2);
         check(baud_o, baud);
      end
      bring(3'h1, 2'h0, 1'b1, 8'h08);
      acyc(1'b0, 2'h0, 3'h1, 2'h0, 1'b0, 8'h00);
      acyc(1'b0, 2'h1, 3'h1, 2'h2, 1'b0, 8'h05);
      acyc(1'b0, 2'h0, 3'h1, 2'h3, 1'b0, 8'h06);
      // slave handed to another master: reads still pass, writes refused
      wait_ready();
      sslave = 3'h1; own = 0; start = 1;
      tick();
      start = 0;
      tick(2);
      acyc(1'b0, 2'h1, 3'h1, 2'h0, 1'b0, 8'h06);
      acyc(1'b0, 2'h0, 3'h1, 2'h0, 1'b0, 8'h00);
      acyc(1'b0, 2'h2, 3'h1, 2'h0, 1'b0, 8'h11);
      acyc(1'b0, 2'h3, 3'h1, 2'h0, 1'b0, 8'h11);
      acyc(1'b0, 2'h0, 3'h1, 2'h0, 1'b1, 8'h17);
      tick(3);
      check({4'h0, state}, 8'h02);
      check({7'h0, prim_open}, 8'h00);
      acyc(1'b0, 2'h0, 3'h1, 2'h0, 1'b0, 8'h11);
      bring(3'h2, 2'h0, 1'b0, 8'h08);
      acyc(1'b0, 2'h0, 3'h2, 2'h0, 1'b0, 8'h11);
      bring(3'h3, 2'h1, 1'b1, 8'h02);
      acyc(1'b1, 2'h0, 3'h4, 2'h0, 1'b0, 8'h11);
      acyc(1'b1, 2'h2, 3'h4, 2'h0, 1'b0, 8'h00);
      acyc(1'b1, 2'h0, 3'h4, 2'h0, 1'b0, 8'h00);
      cid = 3'h4;
      sclose = 1;
      tick();
      sclose = 0;
      tick(2);
      acyc(1'b1, 2'h0, 3'h4, 2'h0, 1'b0, 8'h11);
      acyc(1'b1, 2'h2, 3'h4, 2'h1, 1'b0, 8'h06);
      acyc(1'b1, 2'h2, 3'h5, 2'h0, 1'b0, 8'h00);
      acyc(1'b1, 2'h3, 3'h5, 2'h0, 1'b0, 8'h00);
      acyc(1'b1, 2'h0, 3'h5, 2'h0, 1'b0, 8'h11);
      tick(10);
      tally_and_finish();
   end
endmodule // fdms_sequencer_tb_top
